/* File: rtl/fod_top.sv */
// APB-attached decode and control unit for float and coprocessor operates
`timescale 1ns/1ps
module fod_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Traps and condition code toward the integer unit
  output logic             float_off_trap,
  output logic             coproc_off_trap,
  output logic [1:0]       float_cond_code
);
  import fod_pkg::*;

  // Register state
  logic [7:0]  ctrl_r,    ctrl_nxt;     // Enables, presence, rounding fields
  fod_dec_t    dec_r,     dec_nxt;      // Last issued instruction, decoded
  logic [1:0]  fcc_r,     fcc_nxt;      // Float condition code
  logic        nv_r,      nv_nxt;       // Sticky compare invalid flag
  logic [31:0] src_r,     src_nxt;      // Source word of a move
  logic [31:0] result_r,  result_nxt;   // Result word of a move
  // Bus answer state
  logic [31:0] prdata_r,  prdata_nxt;   // Read data
  logic        pready_r,  pready_nxt;   // Access phase ready
  logic        pslverr_r, pslverr_nxt;  // Unmapped address
  // Trap pulses
  logic        foff_r,    foff_nxt;     // Float disabled pulse
  logic        coff_r,    coff_nxt;     // Coprocessor disabled pulse

  // Decoder of the instruction being written
  fod_dec_t    dec_w;                   // Decode of pwdata
  logic        setup;                   // APB setup cycle
  logic        wr_en;                   // Write takes effect
  logic        mapped;                  // Address is one of ours
  logic        is_cmp;                  // Last issue was a compare

  fod_decode u_decode (
    .instr                 (pwdata),
    .float_enable_bit      (ctrl_r[CTRL_FE]),
    .coproc_enable_bit     (ctrl_r[CTRL_CE]),
    .fpu_present           (ctrl_r[CTRL_FPU]),
    .cp_present            (ctrl_r[CTRL_CPU]),
    .round_precision_field (ctrl_r[CTRL_RP +: 2]),
    .dec                   (dec_w)
  );

  // Bus phase qualifiers
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pready_r & pwrite;
  assign is_cmp = (dec_r.cls == CL_CMP || dec_r.cls == CL_CMPE) && !dec_r.float_off;
  // Address decode
  always_comb begin
    case (paddr)
      REG_INSTR, REG_CTRL, REG_STATUS, REG_FIELDS,
      REG_CMPIN, REG_SRC, REG_RESULT, REG_CLEAR: mapped = 1'b1;
      default:                                     mapped = 1'b0;
    endcase
  end

  // Next-state of the register file and decoder state
  always_comb begin
    logic nv_set;
    logic nv_clr;
    nv_set      = 1'b0;
    nv_clr      = 1'b0;
    ctrl_nxt    = ctrl_r;
    dec_nxt     = dec_r;
    fcc_nxt     = fcc_r;
    src_nxt     = src_r;
    result_nxt  = result_r;
    foff_nxt    = 1'b0;
    coff_nxt    = 1'b0;
    if (wr_en) begin
      case (paddr)
        // Control register
        REG_CTRL: ctrl_nxt = pwdata[7:0];
        // Issue: latch the decode and raise enable traps
        REG_INSTR: begin
          dec_nxt = dec_w;
          foff_nxt = dec_w.float_off;
          coff_nxt = dec_w.coproc_off;
        end
        // Compare outcome from the arithmetic unit
        REG_CMPIN: begin
          if (is_cmp) begin
            fcc_nxt = pwdata[CMPIN_ANYNAN] ? FCC_UNORD : pwdata[1:0];
            nv_set = (dec_r.cls == CL_CMPE) ? pwdata[CMPIN_ANYNAN] : pwdata[CMPIN_SNAN];
          end
        end
        // Move source word, result formed at once
        REG_SRC: begin
          src_nxt = pwdata;
          if (!dec_r.float_off) begin
            case (dec_r.cls)
              CL_MOV:  result_nxt = pwdata;
              CL_NEG:  result_nxt = {~pwdata[31], pwdata[30:0]};
              CL_ABS:  result_nxt = {1'b0, pwdata[30:0]};
              default: result_nxt = result_r;
            endcase
          end
        end
        // Clear the sticky invalid flag
        REG_CLEAR: nv_clr = pwdata[0];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    nv_nxt = (nv_r & ~nv_clr) | nv_set;
  end

  // Next-state of the bus answer
  always_comb begin
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup && !pready_r) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = ~mapped;
      prdata_nxt  = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          REG_INSTR:  prdata_nxt = 32'h0000_0000;
          REG_CTRL:   prdata_nxt = {24'h00_0000, ctrl_r};
          REG_STATUS: prdata_nxt = {10'h000, nv_r, fcc_r, dec_r.unimpl, dec_r.coproc_off,
                                    dec_r.float_off, dec_r.exc, dec_r.rnd, dec_r.writes_dest,
                                    dec_r.dst_prec, dec_r.src_prec, dec_r.cls};
          REG_FIELDS: prdata_nxt = {5'h00, dec_r.opc, 3'h0, dec_r.rd, dec_r.rs1, dec_r.rs2};
          REG_SRC:    prdata_nxt = src_r;
          REG_RESULT: prdata_nxt = result_r;
          default:    prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // Register every state group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= CTRL_RESET;
      dec_r     <= DEC_RESET;
      fcc_r     <= 2'h0;
      nv_r      <= 1'b0;
      src_r     <= 32'h0000_0000;
      result_r  <= 32'h0000_0000;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      foff_r    <= 1'b0;
      coff_r    <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      dec_r     <= dec_nxt;
      fcc_r     <= fcc_nxt;
      nv_r      <= nv_nxt;
      src_r     <= src_nxt;
      result_r  <= result_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      foff_r    <= foff_nxt;
      coff_r    <= coff_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign float_off_trap  = foff_r;
  assign coproc_off_trap = coff_r;
  assign float_cond_code = fcc_r;

  // Checks on decode and bus behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_instr;  // Issue write seen at this edge
  logic wr_src;    // Source write seen at this edge
  logic wr_cmp;    // Compare outcome write seen at this edge
  assign wr_instr = wr_en && paddr == REG_INSTR;
  assign wr_src   = wr_en && paddr == REG_SRC;
  assign wr_cmp   = wr_en && paddr == REG_CMPIN;

  sequence s_setup;
    psel && !penable && !pready;
  endsequence
  sequence s_access;
    pready && psel && penable;
  endsequence

  // Bus answers one cycle after setup
  AST_APB_READY: assert property (s_setup |=> s_access)
    else $error("ready did not follow setup");
  AST_FLOAT_OFF: assert property (wr_instr && (pwdata[24:19] == OP3_FLOAT_A) && !ctrl_r[CTRL_FE]
                                  |=> float_off_trap ##1 !float_off_trap)
    else $error("float disabled trap missing");
  AST_COPROC_OFF: assert property (wr_instr && (pwdata[24:19] == OP3_COPR_B) && !ctrl_r[CTRL_CPU]
                                   |=> coproc_off_trap)
    else $error("coprocessor disabled trap missing");
  AST_NEG_SIGN: assert property (wr_src && dec_r.cls == CL_NEG && !dec_r.float_off
                                 |=> result_r == {~$past(pwdata[31]), $past(pwdata[30:0])})
    else $error("negate result wrong");
  AST_ABS_SIGN: assert property (wr_src && dec_r.cls == CL_ABS && !dec_r.float_off
                                 |=> result_r == {1'b0, $past(pwdata[30:0])})
    else $error("absolute result wrong");
  AST_DZ_DIV_ONLY: assert property (dec_r.exc[EXC_DZ] |-> dec_r.cls == CL_DIV)
    else $error("divide-by-zero on non-divide");
  AST_FTOI_TRUNC: assert property (wr_instr && dec_w.cls == CL_FTOI
                                   |=> dec_r.rnd == RND_ZERO && dec_r.dst_prec == PR_INT)
    else $error("float to integer not truncating");
  AST_CMP_NODEST: assert property (is_cmp |-> !dec_r.writes_dest)
    else $error("compare writes destination");
  AST_FCC_UNORD: assert property (wr_cmp && is_cmp && pwdata[CMPIN_ANYNAN]
                                  |=> float_cond_code == FCC_UNORD)
    else $error("unordered compare code wrong");
  // signalling compare flags invalid on quiet NaN
  AST_CMPE_NV: assert property (wr_cmp && is_cmp && dec_r.cls == CL_CMPE && pwdata[CMPIN_ANYNAN]
                                |=> nv_r [*2])
    else $error("signalling compare missed invalid");
  AST_ALIGN: assert property ((dec_r.dst_prec == PR_EXT |-> dec_r.rd[1:0] == 2'b00) and
                              (dec_r.src_prec == PR_DBL |-> dec_r.rs2[0] == 1'b0))
    else $error("wide register not aligned");
endmodule

/* File: rtl/fod_pkg.sv */
// Shared constants, encodings and types for the float operate decoder
package fod_pkg;
  // Major opcode values of the operate groups
  localparam logic [5:0] OP3_FLOAT_A = 6'h34;  // Float operate, first form
  localparam logic [5:0] OP3_FLOAT_B = 6'h35;  // Float operate, compare form
  localparam logic [5:0] OP3_COPR_A  = 6'h36;  // Coprocessor operate, first form
  localparam logic [5:0] OP3_COPR_B  = 6'h37;  // Coprocessor operate, second form
  // Float operation codes
  localparam logic [8:0] OPF_ITOS = 9'h0C4;
  localparam logic [8:0] OPF_ITOD = 9'h0C8;
  localparam logic [8:0] OPF_ITOX = 9'h0CC;
  localparam logic [8:0] OPF_STOI = 9'h0D1;
  localparam logic [8:0] OPF_DTOI = 9'h0D2;
  localparam logic [8:0] OPF_XTOI = 9'h0D3;
  localparam logic [8:0] OPF_STOD = 9'h0C9;
  localparam logic [8:0] OPF_STOX = 9'h0CD;
  localparam logic [8:0] OPF_DTOS = 9'h0C6;
  localparam logic [8:0] OPF_DTOX = 9'h0CE;
  localparam logic [8:0] OPF_XTOS = 9'h0C7;
  localparam logic [8:0] OPF_XTOD = 9'h0CB;
  localparam logic [8:0] OPF_MOV  = 9'h001;
  localparam logic [8:0] OPF_NEG  = 9'h005;
  localparam logic [8:0] OPF_ABS  = 9'h009;
  localparam logic [6:0] OPF_SQRT = 7'h0A;  // Upper bits, low two give precision
  localparam logic [6:0] OPF_ADD  = 7'h10;
  localparam logic [6:0] OPF_SUB  = 7'h11;
  localparam logic [6:0] OPF_MUL  = 7'h12;
  localparam logic [6:0] OPF_DIV  = 7'h13;
  localparam logic [6:0] OPF_CMP  = 7'h14;
  localparam logic [6:0] OPF_CMPE = 7'h15;
  // Instruction field positions
  localparam int INS_OP3_LSB = 19;
  localparam int INS_RD_LSB  = 25;
  localparam int INS_RS1_LSB = 14;
  localparam int INS_RS2_LSB = 0;
  localparam int INS_OPF_LSB = 5;
  // Exception mask bit positions
  localparam int EXC_NV = 4;
  localparam int EXC_OF = 3;
  localparam int EXC_UF = 2;
  localparam int EXC_DZ = 1;
  localparam int EXC_NX = 0;
  // Round precision value that selects single
  localparam logic [1:0] RP_SINGLE = 2'h1;
  // Condition code values
  localparam logic [1:0] FCC_UNORD = 2'h3;
  // Register byte offsets
  localparam logic [7:0] REG_INSTR  = 8'h00;
  localparam logic [7:0] REG_CTRL   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FIELDS = 8'h0C;
  localparam logic [7:0] REG_CMPIN  = 8'h10;
  localparam logic [7:0] REG_SRC    = 8'h14;
  localparam logic [7:0] REG_RESULT = 8'h18;
  localparam logic [7:0] REG_CLEAR  = 8'h1C;
  // Control register bits and reset value
  localparam int CTRL_FE    = 0;
  localparam int CTRL_CE    = 1;
  localparam int CTRL_FPU   = 2;
  localparam int CTRL_CPU   = 3;
  localparam int CTRL_RD    = 4;
  localparam int CTRL_RP    = 6;
  localparam logic [7:0] CTRL_RESET = 8'h0C;
  // Compare input bits
  localparam int CMPIN_ANYNAN = 2;
  localparam int CMPIN_SNAN   = 3;
  // Operation classes, precisions and rounding sources
  typedef enum logic [3:0] {CL_NONE, CL_ITOF, CL_FTOI, CL_FCONV, CL_MOV, CL_NEG, CL_ABS, CL_SQRT,
                            CL_ADD, CL_SUB, CL_MUL, CL_DIV, CL_CMP, CL_CMPE, CL_COPROC_OPERATE_GROUP} fod_class_t;
  typedef enum logic [1:0] {PR_INT, PR_SGL, PR_DBL, PR_EXT} fod_prec_t;
  typedef enum logic [1:0] {RND_NONE, RND_DIR, RND_DIR_PREC, RND_ZERO} fod_rnd_t;
  // Decoded instruction
  typedef struct packed {
    fod_class_t cls;
    fod_prec_t  src_prec;
    fod_prec_t  dst_prec;
    logic       writes_dest;
    fod_rnd_t   rnd;
    logic [4:0] exc;
    logic       float_off;
    logic       coproc_off;
    logic       unimpl;
    logic [4:0] rd;
    logic [4:0] rs1;
    logic [4:0] rs2;
    logic [8:0] opc;
  } fod_dec_t;
  localparam fod_dec_t DEC_RESET = '0;
endpackage

/* File: rtl/fod_decode.sv */
// Combinational decode of one operate instruction word
`timescale 1ns/1ps
module fod_decode (
  // Instruction and state
  input  wire logic [31:0]      instr,
  input  wire logic             float_enable_bit,
  input  wire logic             coproc_enable_bit,
  input  wire logic             fpu_present,
  input  wire logic             cp_present,
  input  wire logic [1:0]       round_precision_field,
  // Decoded result
  output fod_pkg::fod_dec_t     dec
);
  import fod_pkg::*;

  logic [5:0] major_op_field;  // Major opcode
  logic [8:0] opf;             // Operation code field
  assign major_op_field = instr[INS_OP3_LSB +: 6];
  assign opf            = instr[INS_OPF_LSB +: 9];

  // Clear the address bits a wide operand ignores
  function automatic logic [4:0] align(input logic [4:0] a, input fod_prec_t p);
    case (p)
      PR_DBL:  align = {a[4:1], 1'b0};
      PR_EXT:  align = {a[4:2], 2'b00};
      default: align = a;
    endcase
  endfunction

  // Decode table
  always_comb begin
    fod_prec_t lp;
    lp  = fod_prec_t'(opf[1:0]);
    dec = DEC_RESET;
    dec.opc = opf;
    dec.writes_dest = 1'b1;
    if (major_op_field == OP3_FLOAT_A) begin
      case (opf)
        OPF_ITOS, OPF_ITOD, OPF_ITOX: begin
          dec.cls = CL_ITOF;
          dec.src_prec = PR_INT;
          dec.dst_prec = fod_prec_t'(opf[3:2]);
          if (opf == OPF_ITOS || (opf == OPF_ITOX && round_precision_field == RP_SINGLE)) begin
            dec.rnd = RND_DIR;
            dec.exc[EXC_NX] = 1'b1;
          end
        end
        OPF_STOI, OPF_DTOI, OPF_XTOI: begin
          dec.cls = CL_FTOI;
          dec.src_prec = lp;
          dec.dst_prec = PR_INT;
          dec.rnd = RND_ZERO;
          dec.exc[EXC_NV] = 1'b1;
          dec.exc[EXC_NX] = 1'b1;
        end
        OPF_STOD, OPF_STOX, OPF_DTOS, OPF_DTOX, OPF_XTOS, OPF_XTOD: begin
          dec.cls = CL_FCONV;
          dec.src_prec = lp;
          // Bits three and two of the code name the result format directly
          dec.dst_prec = fod_prec_t'(opf[3:2]);
          if (opf == OPF_DTOS || opf == OPF_XTOS) dec.dst_prec = PR_SGL;
          if (opf == OPF_XTOD) dec.dst_prec = PR_DBL;
          if (opf == OPF_STOD) dec.src_prec = PR_SGL;
          if (opf == OPF_STOX) dec.src_prec = PR_SGL;
          dec.rnd = (opf == OPF_DTOX) ? RND_DIR_PREC : RND_DIR;
          dec.exc = 5'h1D;
        end
        OPF_MOV: begin dec.cls = CL_MOV; dec.src_prec = PR_SGL; dec.dst_prec = PR_SGL; end
        OPF_NEG: begin dec.cls = CL_NEG; dec.src_prec = PR_SGL; dec.dst_prec = PR_SGL; end
        OPF_ABS: begin dec.cls = CL_ABS; dec.src_prec = PR_SGL; dec.dst_prec = PR_SGL; end
        default: begin
          dec.src_prec = lp;
          dec.dst_prec = lp;
          dec.unimpl = (lp == PR_INT);
          case (opf[8:2])
            OPF_SQRT: begin
              dec.cls = CL_SQRT;
              dec.rnd = (lp == PR_EXT) ? RND_DIR_PREC : RND_DIR;
              dec.exc = 5'h11;
            end
            OPF_ADD: begin dec.cls = CL_ADD; dec.rnd = RND_DIR; dec.exc = 5'h0D; end
            OPF_SUB: begin dec.cls = CL_SUB; dec.rnd = RND_DIR; dec.exc = 5'h0D; end
            OPF_MUL: begin dec.cls = CL_MUL; dec.rnd = RND_DIR; dec.exc = 5'h1D; end
            OPF_DIV: begin dec.cls = CL_DIV; dec.rnd = RND_DIR; dec.exc = 5'h1F; end
            default: dec.unimpl = 1'b1;
          endcase
        end
      endcase
    end else if (major_op_field == OP3_FLOAT_B) begin
      dec.writes_dest = 1'b0;
      dec.src_prec = lp;
      dec.dst_prec = lp;
      dec.exc[EXC_NV] = 1'b1;
      dec.unimpl = (lp == PR_INT);
      case (opf[8:2])
        OPF_CMP:  dec.cls = CL_CMP;
        OPF_CMPE: dec.cls = CL_CMPE;
        default:  dec.unimpl = 1'b1;
      endcase
    end else if (major_op_field == OP3_COPR_A || major_op_field == OP3_COPR_B) begin
      dec.cls = CL_COPROC_OPERATE_GROUP;
      dec.writes_dest = 1'b0;
      dec.coproc_off = ~coproc_enable_bit | ~cp_present;
    end else begin
      dec.writes_dest = 1'b0;
    end
    if (dec.cls == CL_NONE) begin
      dec.exc = 5'h00;
      dec.writes_dest = 1'b0;
    end
    if (major_op_field == OP3_FLOAT_A || major_op_field == OP3_FLOAT_B) begin
      dec.float_off = ~float_enable_bit | ~fpu_present;
    end
    dec.rd  = align(instr[INS_RD_LSB +: 5], dec.dst_prec);
    dec.rs1 = align(instr[INS_RS1_LSB +: 5], dec.src_prec);
    dec.rs2 = align(instr[INS_RS2_LSB +: 5], dec.src_prec);
  end
endmodule

/* File: testbench/fod_iu_model.sv */
// Integer-unit side model that takes the trap pulses of the decoder
`timescale 1ns/1ps
module fod_iu_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Traps from the decoder
  input  wire logic       float_off_trap,
  input  wire logic       coproc_off_trap,
  // Counts of traps taken
  output logic      [7:0] float_traps,
  output logic      [7:0] coproc_traps
);
  // issuer spacing kept
  // A non-float step (a register access) always follows a compare before any branch use
  // coprocessor fault choice
  // No coprocessor fault is ever raised here; only disabled traps are counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      float_traps  <= 8'h00;
      coproc_traps <= 8'h00;
    end else begin
      float_traps  <= float_traps + {7'h00, float_off_trap};
      coproc_traps <= coproc_traps + {7'h00, coproc_off_trap};
    end
  end
endmodule

/* File: testbench/test_float_op_decoder.sv */
// Self-checking bench: APB register tests of the float operate decoder
`timescale 1ns/1ps
module test_float_op_decoder;
  import fod_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;  // Bus and clock
  logic [7:0]  paddr;                                                // Byte address
  logic [31:0] pwdata, prdata, rd_v;                                 // Data words
  logic        rd_e, float_off_trap, coproc_off_trap;                // Error and traps
  logic [1:0]  float_cond_code;                                      // Condition code
  logic [7:0]  float_traps, coproc_traps;                            // Trap counts
  int          error_cnt, comparisons, cycles, i;                    // Bookkeeping
  // Operation codes, majors and expected class plus exception mask
  logic [8:0]  t_opf [17] = '{9'h0C4, 9'h0C8, 9'h0CC, 9'h0D1, 9'h0C9, 9'h001, 9'h005, 9'h009, 9'h029,
                              9'h041, 9'h045, 9'h049, 9'h04D, 9'h051, 9'h055, 9'h1A5, 9'h1A5};
  logic [15:0] t_exp [17] = '{16'h0801, 16'h0001, 16'h0801, 16'h8802, 16'hE803, 16'h0004, 16'h0005,
                              16'h0006, 16'h8807, 16'h6808, 16'h6809, 16'hE80A, 16'hF80B, 16'h800C,
                              16'h800D, 16'h000E, 16'h000E};
  fod_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .float_off_trap(float_off_trap), .coproc_off_trap(coproc_off_trap), .float_cond_code(float_cond_code));
  fod_iu_model iu (.pclk(pclk), .presetn(presetn), .float_off_trap(float_off_trap),
    .coproc_off_trap(coproc_off_trap), .float_traps(float_traps), .coproc_traps(coproc_traps));
  // Instruction word with one register number in every field
  function automatic logic [31:0] ins(input logic [5:0] m, input logic [8:0] o, input logic [4:0] r);
    return {2'h2, r, m, r, o, r};
  endfunction
  // Major opcode for table entry
  function automatic logic [5:0] maj(input int k);
    return (k < 13) ? OP3_FLOAT_A : (k < 15) ? OP3_FLOAT_B : (k == 15) ? OP3_COPR_A : OP3_COPR_B;
  endfunction
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the rising edge that samples ready high
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Word comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Move class: issue, load source, read result
  task automatic mv(input logic [8:0] o, input logic [31:0] s, input logic [31:0] e);
    apb(1'b1, REG_INSTR, ins(OP3_FLOAT_A, o, 5'h3));
    apb(1'b1, REG_SRC, s);
    apb(1'b0, REG_RESULT, 32'h0);
    chk(rd_v, e);
  endtask
  // Compare outcome: load inputs, check code port and sticky invalid flag
  task automatic cmpin(input logic [3:0] v, input logic [1:0] f, input logic nv);
    apb(1'b1, REG_CMPIN, {28'h0, v});
    apb(1'b0, REG_STATUS, 32'h0);
    chk({30'h0, float_cond_code}, {30'h0, f});
    chk({31'h0, rd_v[21]}, {31'h0, nv});
  endtask
  // Verdict and end of run
  task automatic finish_test;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Clock of 20 ns period
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {error_cnt, comparisons, cycles} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd_v, {24'h0, CTRL_RESET});
    apb(1'b1, REG_CTRL, 32'h5F);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd_v, 32'h5F);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, rd_e}, 32'h1);
    // Decode table, all units enabled and present, single rounding precision
    for (i = 0; i < 17; i++) begin
      apb(1'b1, REG_INSTR, ins(maj(i), t_opf[i], 5'h7));
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd_v & 32'hF80F, {16'h0, t_exp[i]});
      if (i == 3 || i == 5)
        chk({30'h0, rd_v[10:9]}, (i == 3) ? 32'h3 : 32'h0);
    end
    chk({24'h0, float_traps}, 32'h0);
    apb(1'b1, REG_INSTR, ins(OP3_FLOAT_A, 9'h042, 5'h7));
    apb(1'b0, REG_FIELDS, 32'h0);
    chk(rd_v, 32'h010818C6);
    apb(1'b1, REG_INSTR, ins(OP3_FLOAT_A, 9'h02B, 5'h7));
    apb(1'b0, REG_FIELDS, 32'h0);
    chk(rd_v, 32'h00AC1084);
    apb(1'b1, REG_INSTR, ins(OP3_FLOAT_A, 9'h0C8, 5'h7));
    apb(1'b0, REG_FIELDS, 32'h0);
    chk(rd_v & 32'h7C1F, 32'h1807);
    apb(1'b1, REG_INSTR, ins(OP3_FLOAT_A, 9'h0CD, 5'h7));
    apb(1'b0, REG_FIELDS, 32'h0);
    chk(rd_v, 32'h033410E7);
    mv(9'h001, 32'h80001234, 32'h80001234);
    mv(9'h005, 32'h40001234, 32'hC0001234);
    mv(9'h009, 32'hC0005678, 32'h40005678);
    apb(1'b1, REG_INSTR, ins(OP3_FLOAT_B, 9'h051, 5'h1));
    cmpin(4'h1, 2'h1, 1'b0);
    cmpin(4'h2, 2'h2, 1'b0);
    cmpin(4'h0, 2'h0, 1'b0);
    cmpin(4'h5, FCC_UNORD, 1'b0);
    cmpin(4'hC, FCC_UNORD, 1'b1);
    apb(1'b1, REG_CLEAR, 32'h1);
    apb(1'b1, REG_INSTR, ins(OP3_FLOAT_B, 9'h055, 5'h1));
    cmpin(4'h2, 2'h2, 1'b0);
    cmpin(4'h4, FCC_UNORD, 1'b1);
    // Disabled and absent units trap on issue
    apb(1'b1, REG_CTRL, 32'h5E);
    apb(1'b1, REG_INSTR, ins(OP3_FLOAT_A, 9'h041, 5'h1));
    apb(1'b1, REG_CTRL, 32'h5B);
    apb(1'b1, REG_INSTR, ins(OP3_FLOAT_A, 9'h001, 5'h1));
    apb(1'b1, REG_CTRL, 32'h5D);
    apb(1'b1, REG_INSTR, ins(OP3_COPR_A, 9'h1A5, 5'h1));
    apb(1'b1, REG_CTRL, 32'h57);
    apb(1'b1, REG_INSTR, ins(OP3_COPR_B, 9'h1A5, 5'h1));
    repeat (2) @(posedge pclk);
    chk({24'h0, float_traps}, 32'h2);
    chk({24'h0, coproc_traps}, 32'h2);
    finish_test();
  end
endmodule
